//--- include/pnp_cfg_pkg.sv
// constants, types and key tables for the plug-and-play config block
// How it works
// - irq line register, 4 bits, zero rejected
// - irq kind reads fixed high edge code
// - both dma choices read fixed no-channel code
// - vendor indices mirror live setup A, B, C
// - vendor clear index bit 2 zeroes handle
// - setup A loads raw eeprom value, B and C load masked eeprom values
// - stay quiet until full 32-write key
// - wrong key byte restarts key matching
// - standard and vendor keys both accepted
// - card holds 72-bit serial identifier
// - identifier bits leave bit 0 first
// - first read: one drives 55, zero senses 01
// - second read: drivers AA, floaters sense 10
// - floater seeing both patterns drops to sleep
// - survivors advance one bit, 72 pairs
// - handled cards skip isolation, unhandled cannot wake to config
// - bus reset zeroes handle, waits key
// - wait-key ignores access; wake zero isolates
// - losers sleep; handle moves winner to config
// - read port setup sets address bits 9:2
// - serial isolation read triggers bit compare
// - wake matches handle: zero isolates, else config
package pnp_cfg_pkg;
    localparam logic [15:0] ADDR_PORT = 16'h0279;
    localparam logic [15:0] WDATA_PORT = 16'h0A79;
    localparam logic [7:0] IDX_RD_PORT = 8'h00;
    localparam logic [7:0] IDX_SER_ISO = 8'h01;
    localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
    localparam logic [7:0] IDX_WAKE = 8'h03;
    localparam logic [7:0] IDX_CSN = 8'h06;
    localparam logic [7:0] IDX_IRQ_LINE = 8'h70;
    localparam logic [7:0] IDX_IRQ_KIND = 8'h71;
    localparam logic [7:0] IDX_DMA0 = 8'h74;
    localparam logic [7:0] IDX_DMA1 = 8'h75;
    localparam logic [7:0] IDX_SETUP_A = 8'hF0;
    localparam logic [7:0] IDX_SETUP_B = 8'hF1;
    localparam logic [7:0] IDX_SETUP_C = 8'hF2;
    localparam logic [7:0] IDX_HANDLE_CLR = 8'hF4;
    localparam logic [7:0] IRQ_KIND_VAL = 8'h02;
    localparam logic [7:0] DMA_NONE = 8'h04;
    localparam logic [7:0] ISO_ONE_A = 8'h55;
    localparam logic [7:0] ISO_ONE_B = 8'hAA;
    localparam logic [1:0] SENSE_A = 2'h1;
    localparam logic [1:0] SENSE_B = 2'h2;
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_WAITKEY_BIT = 1;
    localparam int CSN_CLR_BIT = 2;
    localparam logic [6:0] ID_LAST = 7'h47;
    localparam int ID_BYTES = 9;
    localparam logic [4:0] KEY_LAST = 5'h1F;
    localparam logic [7:0] SETUP_B_LOAD_MASK = 8'h13;
    localparam logic [7:0] SETUP_C_LOAD_MASK = 8'h8F;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [3:0] IRQ_LINE_RESET = 4'h0;
    localparam logic [7:0] RD_PORT_RESET = 8'h80;
    localparam logic [7:0] HANDLE_RESET = 8'h00;

    typedef logic [0:31][7:0] key_t;
    localparam key_t KEY_STD = {
        8'h6A, 8'hB5, 8'hDA, 8'hED, 8'hF6, 8'hFB, 8'h7D, 8'hBE,
        8'hDF, 8'h6F, 8'h37, 8'h1B, 8'h0D, 8'h86, 8'hC3, 8'h61,
        8'hB0, 8'h58, 8'h2C, 8'h16, 8'h8B, 8'h45, 8'hA2, 8'hD1,
        8'hE8, 8'h74, 8'h3A, 8'h9D, 8'hCE, 8'hE7, 8'h73, 8'h39};
    localparam key_t KEY_VEND = {
        8'h2A, 8'h95, 8'hCA, 8'hE5, 8'hF2, 8'hF9, 8'hFC, 8'h7E,
        8'hBF, 8'h5F, 8'h2F, 8'h17, 8'h0B, 8'h05, 8'h82, 8'hC1,
        8'hE0, 8'h70, 8'h38, 8'h1C, 8'h0E, 8'h87, 8'h43, 8'h21,
        8'h90, 8'h48, 8'h24, 8'h12, 8'h89, 8'hC4, 8'h62, 8'hB1};

    typedef enum logic [1:0] {WAIT_KEY, SLEEP, ISOLATE, CONFIG} card_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] data;
    } isa_req_s;

    typedef struct packed {
        logic drive;
        logic [7:0] data;
    } isa_rsp_s;

    typedef struct packed {
        logic load;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } setup_load_s;
endpackage : pnp_cfg_pkg

//--- rtl/key_matcher.sv
// tracks progress through one initiation key
`timescale 1ns/100ps
module key_matcher import pnp_cfg_pkg::*; #(
    parameter key_t KEY = KEY_STD
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic strobe,
    input wire logic [7:0] data,
    output logic done
);
    logic [4:0] posQ;
    logic [4:0] posD;
    logic hit;
    logic restart;

    assign hit = data == KEY[posQ];
    // a mismatch that is itself the first byte starts over at byte two
    assign restart = data == KEY[0];
    assign posD = !strobe ? posQ :
                  hit ? (posQ == KEY_LAST ? 5'h00 : posQ + 5'h01) :
                  restart ? 5'h01 : 5'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            posQ <= 5'h00;
            done <= 1'b0;
        end else begin
            posQ <= posD;
            done <= strobe && hit && posQ == KEY_LAST;
        end
    end

    chk_key_restart: assert property (@(posedge clk) disable iff (rst)
        strobe && !hit && !restart |=> posQ == 5'h00)
        else $error("key position not reset on mismatch");
endmodule : key_matcher

//--- rtl/id_store.sv
// nine-byte serial identifier store with registered read
`timescale 1ns/100ps
module id_store import pnp_cfg_pkg::*; (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [3:0] wrAddr,
    input wire logic [7:0] wrData,
    input wire logic [3:0] rdAddr,
    output logic [7:0] rdData
);
    logic [7:0] mem [ID_BYTES];

    // vendor, serial and checksum bytes, filled by the eeprom loader
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule : id_store

//--- rtl/pnp_config.sv
// plug-and-play key, card state, isolation and config registers
`timescale 1ns/100ps
module pnp_config import pnp_cfg_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire isa_req_s busReq,
    input wire setup_load_s eeLoad,
    input wire logic busFaultFlag,
    input wire logic linkOkFlag,
    input wire logic idWrEn,
    input wire logic [3:0] idWrAddr,
    input wire logic [7:0] idWrData,
    input wire logic setupDWr,
    input wire logic [7:0] setupDData,
    output isa_rsp_s busRsp,
    output card_state_e cardState,
    output logic [7:0] cardHandleNumber,
    output logic [3:0] irqLine,
    output logic [9:0] isoReadPort,
    output logic [7:0] setupA,
    output logic [7:0] setupB,
    output logic [7:0] setupC,
    output logic [7:0] setupD,
    output logic logicalReset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    card_state_e stateQ;
    card_state_e stateD;
    logic [7:0] idxQ;
    logic [7:0] handleQ;
    logic [7:0] rdPortQ;
    logic [3:0] irqQ;
    logic [7:0] aQ;
    logic [7:0] bQ;
    logic [7:0] cQ;
    logic [7:0] dQ;
    isa_rsp_s rspQ;
    isa_rsp_s rspD;
    logic resetPulseQ;
    logic [6:0] bitIdxQ;
    logic secondQ;
    logic droveQ;
    logic sense1Q;
    logic pendQ;
    logic pendSecondQ;
    logic isoDoneQ;

    logic [7:0] wrData;
    logic [15:0] rdPortAddr;
    logic onAddr;
    logic onWdata;
    logic onRead;
    logic keyStrobe;
    logic doneStd;
    logic doneVend;
    logic keyDone;
    logic isCfg;
    logic isIso;
    logic wakeWr;
    logic wakeHit;
    logic wakeMiss;
    logic ptrRst;
    logic csnWr;
    logic ctrlWr;
    logic waitKeyCmd;
    logic handleClr;
    logic rdPortWr;
    logic irqWr;
    logic isoRd;
    logic cfgRd;
    logic [7:0] idByte;
    logic curBit;
    logic sampleFirst;
    logic sampleSecond;
    logic isoLose;
    logic isoAdvance;
    logic cfgKnown;
    logic [7:0] cfgData;
    logic [7:0] bLive;
    logic [7:0] bNext;

    // isa decode; the read port keeps address bits 1:0 at one
    assign wrData = busReq.data;
    assign rdPortAddr = {6'h00, rdPortQ, 2'b11};
    assign onAddr = busReq.wr && busReq.addr == ADDR_PORT;
    assign onWdata = busReq.wr && busReq.addr == WDATA_PORT
                     && stateQ != WAIT_KEY;
    assign onRead = busReq.rd && busReq.addr == rdPortAddr
                    && stateQ != WAIT_KEY;
    assign keyStrobe = onAddr && stateQ == WAIT_KEY;
    assign keyDone = doneStd || doneVend;
    assign isCfg = stateQ == CONFIG;
    assign isIso = stateQ == ISOLATE;

    key_matcher #(.KEY(KEY_STD)) u_key_std (
        .clk(clk),
        .rst(rst),
        .strobe(keyStrobe),
        .data(wrData),
        .done(doneStd)
    );

    key_matcher #(.KEY(KEY_VEND)) u_key_vend (
        .clk(clk),
        .rst(rst),
        .strobe(keyStrobe),
        .data(wrData),
        .done(doneVend)
    );

    id_store u_id (
        .clk(clk),
        .wrEn(idWrEn),
        .wrAddr(idWrAddr),
        .wrData(idWrData),
        .rdAddr(bitIdxQ[6:3]),
        .rdData(idByte)
    );

    // write-data port commands
    assign wakeWr = onWdata && idxQ == IDX_WAKE;
    assign wakeHit = wakeWr && wrData == handleQ;
    assign wakeMiss = wakeWr && wrData != handleQ;
    assign ptrRst = wakeHit && wrData == HANDLE_RESET;
    // handles are only taken by the isolation winner or a config card
    assign csnWr = onWdata && idxQ == IDX_CSN
                   && ((isIso && isoDoneQ) || isCfg);
    assign ctrlWr = onWdata && idxQ == IDX_CFG_CTRL;
    assign waitKeyCmd = ctrlWr && wrData[CTRL_WAITKEY_BIT];
    assign handleClr = (ctrlWr && wrData[CSN_CLR_BIT])
                       || (isCfg && onWdata && idxQ == IDX_HANDLE_CLR
                           && wrData[CSN_CLR_BIT]);
    assign rdPortWr = onWdata && isIso && idxQ == IDX_RD_PORT;
    // only a card in config, reached by a handle write or a matching wake, gets its registers
    assign irqWr = onWdata && isCfg && idxQ == IDX_IRQ_LINE
                   && wrData[3:0] != 4'h0;

    // isolation: the current bit walks bit 0 first through each byte
    assign curBit = idByte[bitIdxQ[2:0]];
    assign isoRd = onRead && isIso && !isoDoneQ
                   && idxQ == IDX_SER_ISO;
    assign sampleFirst = pendQ && !pendSecondQ;
    assign sampleSecond = pendQ && pendSecondQ;
    assign isoLose = sampleSecond && sense1Q
                     && busReq.data[1:0] == SENSE_B;
    assign isoAdvance = (isoRd && secondQ && droveQ)
                        || (sampleSecond && !isoLose);

    always_comb begin
        stateD = stateQ;
        case (stateQ)
            WAIT_KEY: begin
                if (keyDone) begin
                    stateD = SLEEP;
                end
            end
            SLEEP: begin
                if (wakeHit) begin
                    stateD = ptrRst ? ISOLATE : CONFIG;
                end
            end
            ISOLATE: begin
                if (isoLose || wakeMiss) begin
                    stateD = SLEEP;
                end else if (csnWr) begin
                    stateD = CONFIG;
                end
            end
            CONFIG: begin
                if (wakeMiss) begin
                    stateD = SLEEP;
                end
            end
            default: stateD = WAIT_KEY;
        endcase
        if (waitKeyCmd) begin
            stateD = WAIT_KEY;
        end
    end

    // config register reads
    assign cfgRd = onRead && isCfg;
    assign cfgKnown = idxQ == IDX_CSN || idxQ == IDX_IRQ_LINE
                      || idxQ == IDX_IRQ_KIND || idxQ == IDX_DMA0
                      || idxQ == IDX_DMA1 || idxQ == IDX_SETUP_A
                      || idxQ == IDX_SETUP_B || idxQ == IDX_SETUP_C;
    assign cfgData =
        idxQ == IDX_CSN ? handleQ :
        idxQ == IDX_IRQ_LINE ? {4'h0, irqQ} :
        idxQ == IDX_IRQ_KIND ? IRQ_KIND_VAL :
        (idxQ == IDX_DMA0 || idxQ == IDX_DMA1) ? DMA_NONE :
        idxQ == IDX_SETUP_A ? aQ :
        idxQ == IDX_SETUP_B ? bQ :
        idxQ == IDX_SETUP_C ? cQ : 8'h00;

    // first read of a pair answers 55, the second AA, ones only
    assign rspD.drive = isoRd ? (secondQ ? droveQ : curBit) :
                        cfgRd && cfgKnown;
    assign rspD.data = isoRd ? (secondQ ? ISO_ONE_B : ISO_ONE_A) :
                       cfgRd ? cfgData : 8'h00;

    // live status bits of setup B follow the controller each cycle
    assign bLive = {2'b00, busFaultFlag, 2'b00, linkOkFlag, 2'b00};
    assign bNext = eeLoad.load ? (eeLoad.b & SETUP_B_LOAD_MASK)
                               : (bQ & SETUP_B_LOAD_MASK);

    always_ff @(posedge clk) begin
        if (rst) begin
            stateQ <= WAIT_KEY;
            idxQ <= 8'h00;
            rspQ <= '0;
            resetPulseQ <= 1'b0;
        end else begin
            stateQ <= stateD;
            if (onAddr && stateQ != WAIT_KEY) begin
                idxQ <= wrData;
            end
            rspQ <= rspD;
            resetPulseQ <= ctrlWr && isCfg && wrData[CTRL_RESET_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            handleQ <= HANDLE_RESET;
            rdPortQ <= RD_PORT_RESET;
            irqQ <= IRQ_LINE_RESET;
        end else begin
            if (handleClr) begin
                handleQ <= HANDLE_RESET;
            end else if (csnWr) begin
                handleQ <= wrData;
            end
            if (rdPortWr) begin
                rdPortQ <= wrData;
            end
            if (ctrlWr && isCfg && wrData[CTRL_RESET_BIT]) begin
                irqQ <= IRQ_LINE_RESET;
            end else if (irqWr) begin
                irqQ <= wrData[3:0];
            end
        end
    end

    // floating cards sample the bus in the cycle after their read
    always_ff @(posedge clk) begin
        if (rst || ptrRst) begin
            bitIdxQ <= 7'h00;
            secondQ <= 1'b0;
            droveQ <= 1'b0;
            sense1Q <= 1'b0;
            pendQ <= 1'b0;
            pendSecondQ <= 1'b0;
            isoDoneQ <= 1'b0;
        end else begin
            pendQ <= isoRd && !(secondQ ? droveQ : curBit);
            pendSecondQ <= secondQ;
            if (isoRd) begin
                secondQ <= !secondQ;
                if (!secondQ) begin
                    droveQ <= curBit;
                end
            end
            if (sampleFirst) begin
                sense1Q <= busReq.data[1:0] == SENSE_A;
            end
            if (isoAdvance) begin
                if (bitIdxQ == ID_LAST) begin
                    isoDoneQ <= 1'b1;
                end else begin
                    bitIdxQ <= bitIdxQ + 7'h01;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aQ <= SETUP_RESET;
            bQ <= SETUP_RESET;
            cQ <= SETUP_RESET;
            dQ <= SETUP_RESET;
        end else begin
            if (eeLoad.load) begin
                aQ <= eeLoad.a;
                cQ <= eeLoad.c & SETUP_C_LOAD_MASK;
            end
            bQ <= bNext | bLive;
            if (setupDWr) begin
                dQ <= setupDData;
            end
        end
    end

    assign busRsp = rspQ;
    assign cardState = stateQ;
    assign cardHandleNumber = handleQ;
    assign irqLine = irqQ;
    assign isoReadPort = rdPortAddr[9:0];
    assign setupA = aQ;
    assign setupB = bQ;
    assign setupC = cQ;
    assign setupD = dQ;
    assign logicalReset = resetPulseQ;

    // reset is the trigger here, so the default disable must not apply
    chk_bus_reset: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> stateQ == WAIT_KEY && handleQ == HANDLE_RESET)
        else $error("reset did not clear handle and state");
    chk_wait_quiet: assert property (
        stateQ == WAIT_KEY ##1 stateQ == WAIT_KEY |-> !busRsp.drive)
        else $error("card answered while waiting for key");
    chk_key_sleep: assert property (
        stateQ == WAIT_KEY && keyDone && !waitKeyCmd
        |=> stateQ == SLEEP)
        else $error("completed key did not reach sleep");
    chk_kind_const: assert property (
        cfgRd && idxQ == IDX_IRQ_KIND
        |=> busRsp.drive && busRsp.data == 8'h02)
        else $error("irq kind read wrong");
    chk_dma_const: assert property (
        cfgRd && (idxQ == IDX_DMA0 || idxQ == IDX_DMA1)
        |=> busRsp.drive && busRsp.data == 8'h04)
        else $error("dma choice read wrong");
    chk_handle_clear: assert property (
        isCfg && onWdata && idxQ == IDX_HANDLE_CLR && wrData[2]
        |=> cardHandleNumber == 8'h00)
        else $error("handle not cleared");
    chk_irq_zero_kept: assert property (
        isCfg && onWdata && idxQ == IDX_IRQ_LINE && wrData[3:0] == 4'h0
        && !ctrlWr |=> $stable(irqLine))
        else $error("zero irq selection accepted");
    chk_iso_one_pair: assert property (
        isoRd && !secondQ && curBit
        |=> busRsp.drive && busRsp.data == 8'h55
        ##[1:1000] (busRsp.drive && busRsp.data == 8'hAA)
        || stateQ != ISOLATE)
        else $error("driving card pair not 55 then AA");
    chk_loser_sleep: assert property (
        isoLose && !waitKeyCmd |=> stateQ == SLEEP)
        else $error("losing card not back to sleep");
    chk_wake_zero: assert property (
        stateQ == SLEEP && wakeHit && wrData == 8'h00 && !waitKeyCmd
        |=> stateQ == ISOLATE && bitIdxQ == 7'h00 && !isoDoneQ)
        else $error("wake zero did not restart isolation");
    chk_port_set: assert property (
        rdPortWr |=> isoReadPort == {$past(wrData), 2'b11})
        else $error("read port address wrong");

    cov_key_done: cover property (stateQ == WAIT_KEY ##1 stateQ == SLEEP);
    cov_iso_win: cover property (isIso && isoDoneQ);
    cov_to_config: cover property (isIso ##1 isCfg);
    cov_loser: cover property (isoLose);
endmodule : pnp_config

//--- dv/isa_host_model.sv
// host-side bus model: strobes, read port and resolved data level
`timescale 1ns/100ps
module isa_host_model import pnp_cfg_pkg::*; #(
    parameter int FIRST_WAIT = 20,
    parameter int PAIR_WAIT = 10
) (
    input wire logic clk,
    input wire isa_rsp_s busRsp,
    output isa_req_s busReq
);
    logic [15:0] rdPort = 16'h0203;
    // the data bus has pull-ups: released, it reads FF, not the last value
    initial busReq = {2'b00, 16'h0000, 8'hFF};

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 busReq = {2'b10, a, d};
        @(posedge clk);
        #1 busReq = {2'b00, 16'h0000, 8'hFF};
    endtask : wr

    // other: level put on the bus by a rival card, FF when none
    task automatic rd(input logic [7:0] other, output isa_rsp_s got,
                      output logic [7:0] lvl);
        @(posedge clk);
        #1 busReq = {2'b01, rdPort, 8'hFF};
        @(posedge clk);
        #1 got = busRsp;
        lvl = busRsp.drive ? busRsp.data : other;
        busReq = {2'b00, 16'h0000, lvl};
        @(posedge clk);
        #1 busReq = {2'b00, 16'h0000, 8'hFF};
        // id byte fetch is registered, so keep reads apart
        @(posedge clk);
    endtask : rd

    task automatic setRdPort(input logic [7:0] b);
        wr(ADDR_PORT, IDX_RD_PORT);
        wr(WDATA_PORT, b);
        rdPort = {6'h00, b, 2'b11};
    endtask : setRdPort

    task automatic startIso();
        wr(ADDR_PORT, IDX_SER_ISO);
        repeat (FIRST_WAIT) @(posedge clk);
    endtask : startIso

    task automatic pair(input logic [7:0] o1, input logic [7:0] o2,
                        output isa_rsp_s r1, output isa_rsp_s r2,
                        output logic bitv);
        logic [7:0] l1;
        logic [7:0] l2;
        rd(o1, r1, l1);
        rd(o2, r2, l2);
        bitv = (l1 === 8'h55) && (l2 === 8'hAA);
        repeat (PAIR_WAIT) @(posedge clk);
    endtask : pair
endmodule : isa_host_model

//--- dv/tb_pnp_config.sv
// self-checking bench for the plug-and-play config block
`timescale 1ns/100ps
module tb_pnp_config import pnp_cfg_pkg::*;;
    localparam int LIMIT = 20000;
    localparam logic [0:8][7:0] ID = {8'h5A, 8'h3C, 8'h01, 8'h80,
        8'hF0, 8'h0F, 8'hC3, 8'h96, 8'h7E};
    localparam logic [0:2][7:0] RO_IDX = {8'h71, 8'h74, 8'h75};
    localparam logic [0:2][7:0] RO_VAL = {8'h02, 8'h04, 8'h04};
    localparam logic [0:2][7:0] SU_IDX = {8'hF0, 8'hF1, 8'hF2};
    localparam logic [0:2][7:0] SU_VAL = {8'hA5, 8'h33, 8'h8F};
    logic clk, rst, busFaultFlag, linkOkFlag, idWrEn, setupDWr;
    logic [3:0] idWrAddr, irqLine;
    logic [7:0] idWrData, setupDData, cardHandleNumber;
    logic [7:0] setupA, setupB, setupC, setupD;
    logic [9:0] isoReadPort;
    logic logicalReset, bitv;
    isa_req_s busReq;
    isa_rsp_s busRsp, r1, r2;
    setup_load_s eeLoad;
    card_state_e cardState;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    pnp_config i_pnp_config (.clk(clk), .rst(rst), .busReq(busReq),
        .eeLoad(eeLoad), .busFaultFlag(busFaultFlag),
        .linkOkFlag(linkOkFlag), .idWrEn(idWrEn), .idWrAddr(idWrAddr),
        .idWrData(idWrData), .setupDWr(setupDWr), .setupDData(setupDData),
        .busRsp(busRsp), .cardState(cardState),
        .cardHandleNumber(cardHandleNumber), .irqLine(irqLine),
        .isoReadPort(isoReadPort), .setupA(setupA), .setupB(setupB),
        .setupC(setupC), .setupD(setupD), .logicalReset(logicalReset));
    isa_host_model i_isa_host_model (.clk(clk), .busRsp(busRsp),
        .busReq(busReq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t run did not finish in time", $time);
            final_report();
        end
    end

    task automatic chkVal(input logic [15:0] got, input logic [15:0] exp,
                          input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chkVal

    task automatic chkRsp(input isa_rsp_s got, input isa_rsp_s exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t read got %h exp %h", $time, got, exp);
        end
    endtask : chkRsp

    task automatic chkSt(input card_state_e e);
        chkVal({14'h0000, cardState}, {14'h0000, e}, "state");
    endtask : chkSt

    task automatic settle();
        repeat (2) @(posedge clk);
        #2;
    endtask : settle

    task automatic regWr(input logic [7:0] idx, input logic [7:0] d);
        i_isa_host_model.wr(ADDR_PORT, idx);
        i_isa_host_model.wr(WDATA_PORT, d);
        settle();
    endtask : regWr

    task automatic regRd(input logic [7:0] idx, output isa_rsp_s r);
        logic [7:0] lv;
        i_isa_host_model.wr(ADDR_PORT, idx);
        i_isa_host_model.rd(8'hFF, r, lv);
    endtask : regRd

    // a byte replaced by 00 at position bad, none when bad is 32
    task automatic sendKey(input key_t k, input int bad);
        for (int i = 0; i < 32; i++) begin
            i_isa_host_model.wr(ADDR_PORT, (i == bad) ? 8'h00 : k[i]);
        end
        settle();
    endtask : sendKey

    initial begin
        logic b;
        isa_rsp_s r;
        rst = 1'b1;
        eeLoad = '0;
        busFaultFlag = 1'b1;
        linkOkFlag = 1'b0;
        idWrEn = 1'b0;
        idWrAddr = 4'h0;
        idWrData = 8'h00;
        setupDWr = 1'b0;
        setupDData = 8'h00;
        for (int k = 0; k < 9; k++) begin
            @(posedge clk);
            #1 idWrEn = 1'b1;
            idWrAddr = k[3:0];
            idWrData = ID[k];
        end
        @(posedge clk);
        #1 idWrEn = 1'b0;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        repeat (10) @(posedge clk);
        #2;
        chkSt(WAIT_KEY);
        chkVal({8'h00, cardHandleNumber}, 16'h0000, "handle");
        chkVal({6'h00, isoReadPort}, 16'h0203, "port");
        chkVal({8'h00, setupD}, 16'h0000, "setup d");
        regWr(IDX_WAKE, 8'h00);
        chkSt(WAIT_KEY);
        sendKey(KEY_STD, 10);
        chkSt(WAIT_KEY);
        sendKey(KEY_STD, 32);
        chkSt(SLEEP);
        regWr(IDX_WAKE, 8'h00);
        chkSt(ISOLATE);
        i_isa_host_model.setRdPort(8'hC0);
        settle();
        chkVal({6'h00, isoReadPort}, 16'h0303, "port");
        regRd(IDX_IRQ_KIND, r);
        chkRsp(r, 9'h000);
        // no rival on the bus: this card must survive all 72 pairs
        i_isa_host_model.startIso();
        for (int i = 0; i < 72; i++) begin
            b = ID[i / 8][i % 8];
            i_isa_host_model.pair(8'hFF, 8'hFF, r1, r2, bitv);
            chkRsp(r1, {b, ISO_ONE_A});
            chkRsp(r2, {b, ISO_ONE_B});
            chkVal({15'h0000, bitv}, {15'h0000, b}, "id bit");
        end
        chkSt(ISOLATE);
        regWr(IDX_CSN, 8'h01);
        chkSt(CONFIG);
        for (int k = 0; k < 3; k++) begin
            regWr(RO_IDX[k], 8'h5A);
            regRd(RO_IDX[k], r);
            chkRsp(r, {1'b1, RO_VAL[k]});
        end
        regWr(IDX_IRQ_LINE, 8'h0F);
        regWr(IDX_IRQ_LINE, 8'h00);
        chkVal({12'h000, irqLine}, 16'h000F, "irq line");
        regRd(IDX_IRQ_LINE, r);
        chkRsp(r, {1'b1, 8'h0F});
        // the reset pulse stands one cycle: look right after the write
        i_isa_host_model.wr(ADDR_PORT, IDX_CFG_CTRL);
        i_isa_host_model.wr(WDATA_PORT, 8'h01);
        chkVal({15'h0000, logicalReset}, 16'h0001, "reset pulse");
        settle();
        chkVal({12'h000, irqLine}, 16'h0000, "irq line");
        @(posedge clk);
        #1 eeLoad = {1'b1, 8'hA5, 8'hFF, 8'hFF};
        @(posedge clk);
        #1 eeLoad.load = 1'b0;
        for (int k = 0; k < 3; k++) begin
            regRd(SU_IDX[k], r);
            chkRsp(r, {1'b1, SU_VAL[k]});
        end
        chkVal({8'h00, setupA}, 16'h00A5, "setup a");
        chkVal({8'h00, setupB}, 16'h0033, "setup b");
        chkVal({8'h00, setupC}, 16'h008F, "setup c");
        #1 linkOkFlag = 1'b1;
        regRd(IDX_SETUP_B, r);
        chkRsp(r, {1'b1, 8'h37});
        regWr(IDX_WAKE, 8'h00);
        chkSt(SLEEP);
        regWr(IDX_WAKE, 8'h00);
        chkSt(SLEEP);
        regWr(IDX_WAKE, 8'h01);
        chkSt(CONFIG);
        regWr(IDX_HANDLE_CLR, 8'hFB);
        chkVal({8'h00, cardHandleNumber}, 16'h0001, "handle");
        regWr(IDX_HANDLE_CLR, 8'h04);
        chkVal({8'h00, cardHandleNumber}, 16'h0000, "handle");
        regWr(IDX_WAKE, 8'h05);
        chkSt(SLEEP);
        regWr(IDX_WAKE, 8'h00);
        chkSt(ISOLATE);
        // rival patterns differ from 55/AA above the low two bits
        i_isa_host_model.startIso();
        i_isa_host_model.pair(8'hF5, 8'h0A, r1, r2, bitv);
        chkRsp(r1, {1'b0, ISO_ONE_A});
        chkSt(SLEEP);
        regWr(IDX_WAKE, 8'h00);
        chkSt(ISOLATE);
        // give setup D a value so the mid-run reset has to clear it
        @(posedge clk);
        #1 setupDWr = 1'b1;
        setupDData = 8'h5A;
        @(posedge clk);
        #1 setupDWr = 1'b0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        settle();
        chkSt(WAIT_KEY);
        chkVal({8'h00, setupD}, 16'h0000, "setup d");
        sendKey(KEY_VEND, 32);
        chkSt(SLEEP);
        final_report();
    end
endmodule : tb_pnp_config
